// *** rtl/sgs_defines.svh ***
/*
  Constants of the setting group selector: register offsets, reset values,
  field positions and choice encodings.
  Assumes it is included by bare name from the package and the selector.
*/
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH

`define SGS_ADDR_W        8
`define SGS_DATA_W        32
`define SGS_NUM_GRP       8
`define SGS_IDX_W         3
`define SGS_CHOICE_W      4

`define SGS_OFF_ACTIVE    8'h00
`define SGS_OFF_FORCE_EN  8'h04
`define SGS_OFF_FORCE_GRP 8'h08
`define SGS_OFF_USED      8'h0c
`define SGS_OFF_REMOTE    8'h10
`define SGS_OFF_MODE      8'h14
`define SGS_OFF_STATUS    8'h18

`define SGS_RST_ACTIVE    3'h0
`define SGS_RST_FORCE_EN  1'b0
`define SGS_RST_CHOICE    4'h0
`define SGS_RST_USED      3'h0
`define SGS_RST_MODE      8'h00
`define SGS_RST_FAIL      3'h0

`define SGS_CHOICE_NONE   4'h0
`define SGS_CHOICE_MAX    4'h8
`define SGS_CHOICE_ONE    4'h1

`define SGS_FAIL_FORCE    0
`define SGS_FAIL_UNCFG    1
`define SGS_FAIL_PRIO     2

`define SGS_PAD_IDX       29'h0
`define SGS_PAD_BIT       31'h0
`define SGS_PAD_CHOICE    28'h0
`define SGS_PAD_MASK      24'h0
`define SGS_PAD_STATUS    21'h0

`endif

// *** rtl/sgs_pkg.sv ***
/*
  Types of the setting group selector.
  Assumes sgs_defines.svh is on the include path.
*/
`include "sgs_defines.svh"

package sgs_pkg;
    typedef logic [`SGS_NUM_GRP-1:0] sgs_mask_type;
    typedef logic [`SGS_IDX_W-1:0]   sgs_idx_type;

    typedef struct packed {
        logic [`SGS_ADDR_W-1:0] addr;
        logic [`SGS_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } sgs_bus_req_type;

    typedef struct packed {
        logic        found;
        sgs_idx_type idx;
    } sgs_pick_type;
endpackage

// *** rtl/sgs_selector.sv ***
/*
  Setting group selector: picks one active group of eight from per-group
  pulse or level requests, a remote choice and a forced choice.
  Assumes one clock, request inputs that may come from pins, and a simple
  register port with read data one cycle after the read strobe.
*/
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sgs_defines.svh"

module sgs_selector
    import sgs_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire sgs_bus_req_type bus_req,
    output var  logic [31:0]     rd_data,
    input  wire sgs_mask_type    group_request,
    output var  sgs_idx_type     active_group,
    output var  sgs_mask_type    active_onehot,
    output var  sgs_mask_type    group_enabled,
    output var  logic            force_enable
);

    // mask of groups 0..n inclusive
    function automatic sgs_mask_type sgs_upto(input sgs_idx_type n);
        sgs_mask_type m;
        m = '0;
        for (int i = 0; i < `SGS_NUM_GRP; i++) begin
            m[i] = (i <= int'(n));
        end
        return m;
    endfunction

    // lowest index wins: group one has the highest rank
    function automatic sgs_pick_type sgs_first(input sgs_mask_type m);
        sgs_pick_type p;
        p = '0;
        for (int i = `SGS_NUM_GRP - 1; i >= 0; i--) begin
            if (m[i]) begin
                p.found = 1'b1;
                p.idx   = sgs_idx_type'(i);
            end
        end
        return p;
    endfunction

    function automatic sgs_mask_type sgs_onehot(input sgs_idx_type n);
        sgs_mask_type m;
        m    = '0;
        m[n] = 1'b1;
        return m;
    endfunction

    function automatic sgs_idx_type sgs_choice_idx(input logic [3:0] v);
        logic [3:0] d;
        d = v - `SGS_CHOICE_ONE;
        return d[2:0];
    endfunction

    // a choice names a group that is within range and in use
    function automatic logic sgs_choice_ok(input logic [3:0] v,
                                           input sgs_idx_type used);
        return (v != `SGS_CHOICE_NONE) && (v <= `SGS_CHOICE_MAX)
               && (sgs_choice_idx(v) <= used);
    endfunction

    logic            rst_s1_q;
    logic            rst_n_q;
    sgs_mask_type    req_s1_q;
    sgs_mask_type    req_s2_q;
    sgs_mask_type    req_s3_q;
    sgs_mask_type    req_filt_q;
    sgs_mask_type    req_filt_d;
    sgs_mask_type    req_prev_q;
    logic            force_en_q;
    logic [3:0]      force_grp_q;
    logic [3:0]      remote_q;
    sgs_idx_type     used_q;
    sgs_mask_type    mode_q;
    sgs_idx_type     active_q;
    sgs_idx_type     active_d;
    sgs_mask_type    onehot_q;
    sgs_mask_type    enabled_q;
    logic [2:0]      fail_q;
    logic [2:0]      fail_d;
    logic [31:0]     rd_data_q;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // three-stage synchroniser; a change counts once stages two and three agree
    assign req_filt_d = (req_s2_q & req_s3_q) | (req_filt_q & (req_s2_q ^ req_s3_q));

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            req_s1_q   <= '0;
            req_s2_q   <= '0;
            req_s3_q   <= '0;
            req_filt_q <= '0;
            req_prev_q <= '0;
        end else begin
            req_s1_q   <= group_request;
            req_s2_q   <= req_s1_q;
            req_s3_q   <= req_s2_q;
            req_filt_q <= req_filt_d;
            req_prev_q <= req_filt_q;
        end
    end

    // register decode
    wire wr_force_en  = bus_req.wr && (bus_req.addr == `SGS_OFF_FORCE_EN);
    wire wr_force_grp = bus_req.wr && (bus_req.addr == `SGS_OFF_FORCE_GRP);
    wire wr_used      = bus_req.wr && (bus_req.addr == `SGS_OFF_USED);
    wire wr_remote    = bus_req.wr && (bus_req.addr == `SGS_OFF_REMOTE);
    wire wr_mode      = bus_req.wr && (bus_req.addr == `SGS_OFF_MODE);
    wire rd_status    = bus_req.rd && (bus_req.addr == `SGS_OFF_STATUS);
    wire [3:0] wr_choice = bus_req.wdata[3:0];

    // group classification
    wire sgs_mask_type used_mask = sgs_upto(used_q);
    wire sgs_mask_type edges     = req_filt_q & ~req_prev_q;
    wire sgs_mask_type held      = req_filt_q & mode_q & used_mask;
    wire sgs_mask_type pulses    = edges & ~mode_q & used_mask;
    wire sgs_mask_type outside   = (edges | req_filt_q) & ~used_mask;

    // highest held level masks everything ranked below it; group eight masks nothing
    wire sgs_pick_type held_top  = sgs_first(held);
    wire sgs_mask_type allow     = held_top.found ? sgs_upto(held_top.idx)
                                                  : '1;
    wire sgs_mask_type auto_req  = (held | pulses) & allow;
    wire               auto_lost = |(pulses & ~allow);
    wire sgs_pick_type auto_pick = sgs_first(auto_req);

    // forced choice: a pulse-type request, taken only with force enabled
    wire         force_ok  = wr_force_grp && force_en_q
                             && sgs_choice_ok(wr_choice, used_q);
    wire         force_bad = wr_force_grp && force_en_q
                             && (wr_choice != `SGS_CHOICE_NONE)
                             && !sgs_choice_ok(wr_choice, used_q);
    wire sgs_idx_type force_idx = sgs_choice_idx(wr_choice);

    // remote choice also needs force, and loses to a held higher-ranked level
    wire         remote_cfg  = wr_remote && force_en_q
                               && sgs_choice_ok(wr_choice, used_q);
    wire sgs_idx_type remote_idx = sgs_choice_idx(wr_choice);
    wire         remote_prio = remote_cfg && held_top.found
                               && (remote_idx > held_top.idx);
    wire         remote_ok   = remote_cfg && !remote_prio;
    wire         remote_bad  = wr_remote && force_en_q
                               && (wr_choice != `SGS_CHOICE_NONE)
                               && !sgs_choice_ok(wr_choice, used_q);

    // a change asked for while force is off is refused
    wire         refused   = (wr_force_grp || wr_remote) && !force_en_q
                             && (wr_choice != `SGS_CHOICE_NONE);

    // one group in use: the selector is idle on group one
    wire         idle      = (used_q == `SGS_RST_USED);

    always_comb begin
        active_d = active_q;
        if (idle) begin
            active_d = `SGS_RST_ACTIVE;
        end else if (force_en_q) begin
            // inputs ignored; only a forced or accepted remote choice, or shrinking the in-use range, moves it
            if (force_ok) begin
                active_d = force_idx;
            end else if (remote_ok) begin
                active_d = remote_idx;
            end
        end else if (auto_pick.found) begin
            // levels act at once after force clears
            active_d = auto_pick.idx;
        end
        // shrinking the in-use range never leaves a dead group active
        if (active_d > used_q) begin
            active_d = `SGS_RST_ACTIVE;
        end
    end

    // refusal flags: set wins over the clear-on-read of the status word
    always_comb begin
        fail_d = rd_status ? `SGS_RST_FAIL : fail_q;
        if (refused) begin
            fail_d[`SGS_FAIL_FORCE] = 1'b1;
        end
        if (force_bad || remote_bad || (!idle && |outside && !force_en_q)) begin
            fail_d[`SGS_FAIL_UNCFG] = 1'b1;
        end
        if (remote_prio || (auto_lost && !force_en_q && !idle)) begin
            fail_d[`SGS_FAIL_PRIO] = 1'b1;
        end
    end

    // software settings
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            force_en_q  <= `SGS_RST_FORCE_EN;
            force_grp_q <= `SGS_RST_CHOICE;
            remote_q    <= `SGS_RST_CHOICE;
            used_q      <= `SGS_RST_USED;
            mode_q      <= `SGS_RST_MODE;
        end else begin
            if (wr_force_en) begin
                force_en_q <= bus_req.wdata[0];
            end
            if (wr_force_grp) begin
                force_grp_q <= wr_choice;
            end
            if (wr_remote) begin
                remote_q <= wr_choice;
            end
            if (wr_used) begin
                used_q <= bus_req.wdata[2:0];
            end
            if (wr_mode) begin
                mode_q <= bus_req.wdata[7:0];
            end
        end
    end

    // active group state, updated the cycle after the winning request
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            active_q  <= `SGS_RST_ACTIVE;
            onehot_q  <= sgs_mask_type'(1);
            enabled_q <= sgs_mask_type'(1);
            fail_q    <= `SGS_RST_FAIL;
        end else begin
            active_q  <= active_d;
            onehot_q  <= sgs_onehot(active_d);
            enabled_q <= used_mask;
            fail_q    <= fail_d;
        end
    end

    // read data, one cycle after the strobe; unmapped addresses read zero
    wire [31:0] rd_mux =
        (bus_req.addr == `SGS_OFF_ACTIVE)    ? {`SGS_PAD_IDX, active_q} :
        (bus_req.addr == `SGS_OFF_FORCE_EN)  ? {`SGS_PAD_BIT, force_en_q} :
        (bus_req.addr == `SGS_OFF_FORCE_GRP) ? {`SGS_PAD_CHOICE, force_grp_q} :
        (bus_req.addr == `SGS_OFF_USED)      ? {`SGS_PAD_IDX, used_q} :
        (bus_req.addr == `SGS_OFF_REMOTE)    ? {`SGS_PAD_CHOICE, remote_q} :
        (bus_req.addr == `SGS_OFF_MODE)      ? {`SGS_PAD_MASK, mode_q} :
        (bus_req.addr == `SGS_OFF_STATUS)    ? {`SGS_PAD_STATUS, fail_q, req_filt_q} :
                                               '0;

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= bus_req.rd ? rd_mux : '0;
        end
    end

    assign rd_data       = rd_data_q;
    assign active_group  = active_q;
    assign active_onehot = onehot_q;
    assign group_enabled = enabled_q;
    assign force_enable  = force_en_q;

endmodule
`default_nettype wire

// *** test/sgs_request_source.sv ***
/*
  Far side model: user logic and digital inputs driving group requests.
  Assumes the bench gives levels and one-cycle pulse strobes on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_request_source
    import sgs_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire sgs_mask_type level_req,
    input  wire sgs_mask_type pulse_req,
    output var  sgs_mask_type group_request
);
    sgs_mask_type pulse_q;
    logic [2:0]   hold_q;

    // four cycles: shorter pulses may slip through the input filter unseen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= 8'h00;
            hold_q  <= 3'h0;
        end else if (pulse_req != 8'h00) begin
            pulse_q <= pulse_req;
            hold_q  <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end

    assign group_request = level_req | (hold_q != 3'h0 ? pulse_q : 8'h00);
endmodule
`default_nettype wire

// *** test/sgs_selector_properties.sv ***
/*
  Port assertions for the setting group selector.
  Assumes it is bound into every sgs_selector and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_selector_props
    import sgs_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire sgs_bus_req_type bus_req,
    input  wire logic [31:0]     rd_data,
    input  wire sgs_mask_type    group_request,
    input  wire sgs_idx_type     active_group,
    input  wire sgs_mask_type    active_onehot,
    input  wire sgs_mask_type    group_enabled,
    input  wire logic            force_enable
);
    sgs_mask_type mode_q;
    wire          mode_wr = bus_req.wr && bus_req.addr == 8'h14;

    // the mode is not on a port, so a level can only be judged by mirroring it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            mode_q <= 8'h00;
        else if (mode_wr)
            mode_q <= bus_req.wdata[7:0];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    one_active_a: assert property (
        active_onehot == (8'h01 << active_group))
        else $error("active one-hot disagrees with index");
    used_shape_a: assert property (
        group_enabled[0] && ((group_enabled + 8'h01) & group_enabled) == 8'h00)
        else $error("enabled mask not a run from group one");
    single_idle_a: assert property (
        group_enabled == 8'h01 && $past(group_enabled) == 8'h01 |-> active_group == 3'h0)
        else $error("active group moved with one group in use");
    in_range_a: assert property (
        $stable(group_enabled) ##1 $stable(group_enabled) |-> group_enabled[active_group])
        else $error("active group outside the enabled range");
    read_active_a: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == 8'h00
        |-> rd_data == {29'h0, $past(active_group)})
        else $error("active group read back wrong");
    force_hold_a: assert property (
        $changed(force_enable) |-> $past(bus_req.wr) && $past(bus_req.addr) == 8'h04
        && $past(bus_req.wdata[0]) == force_enable)
        else $error("force enable changed without a write");
    force_freeze_a: assert property (
        force_enable && $past(force_enable) && !$past(bus_req.wr) && $stable(group_enabled)
        |-> $stable(active_group))
        else $error("active group moved while forced");
    level_one_a: assert property (
        (group_request[0] && mode_q[0] && !force_enable)[*8] |-> active_group == 3'h0)
        else $error("group one level did not hold group one");
endmodule

bind sgs_selector sgs_selector_props u_props (
    .sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
    .group_request(group_request), .active_group(active_group),
    .active_onehot(active_onehot), .group_enabled(group_enabled),
    .force_enable(force_enable)
);
`default_nettype wire

// *** test/testbench.sv ***
/*
  Self-checking bench for the setting group selector.
  Assumes the selector, its package and the request source model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sgs_pkg::*;
;
    typedef struct packed {
        sgs_mask_type lvl;
        sgs_mask_type pls;
        sgs_idx_type  exp;
    } sgs_row_type;
    // mode a5: groups 1, 3, 6 and 8 are level inputs, the rest pulse inputs
    localparam sgs_row_type ROWS [8] = '{
        '{8'h00, 8'h02, 3'h1}, '{8'h00, 8'h48, 3'h3}, '{8'h80, 8'h00, 3'h7},
        '{8'h00, 8'h10, 3'h4}, '{8'h24, 8'h00, 3'h2}, '{8'h04, 8'h08, 3'h2},
        '{8'h01, 8'h02, 3'h0}, '{8'h00, 8'h00, 3'h0}};
    localparam logic [7:0] RADDR [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};

    logic            sys_clk;
    logic            nrst;
    sgs_bus_req_type bus_req;
    logic [31:0]     rd_data;
    sgs_mask_type    lvl, pls, group_request, active_onehot, group_enabled;
    sgs_idx_type     active_group;
    logic            force_enable;
    int              failures, tests_run, cycles;

    sgs_selector uut (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
        .rd_data(rd_data), .group_request(group_request),
        .active_group(active_group), .active_onehot(active_onehot),
        .group_enabled(group_enabled), .force_enable(force_enable));
    sgs_request_source src (.sys_clk(sys_clk), .nrst(nrst), .level_req(lvl),
        .pulse_req(pls), .group_request(group_request));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 check(rd_data, exp);
    endtask

    task automatic send(input sgs_mask_type l, input sgs_mask_type p);
        @(posedge sys_clk);
        lvl <= l;
        pls <= p;
        @(posedge sys_clk);
        pls <= 8'h00;
    endtask

    // ten cycles covers the input filter plus the one-cycle decision
    task automatic expect_grp(input sgs_idx_type e);
        repeat (10) @(posedge sys_clk);
        #1 check({29'h0, active_group}, {29'h0, e});
    endtask

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        nrst = 1'b0;
        bus_req = '0;
        lvl = 8'h00;
        pls = 8'h00;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check({16'h0, active_onehot, group_enabled}, 32'h0101);
        foreach (RADDR[i]) reg_rd(RADDR[i], 32'h0);
        send(8'h00, 8'h02);
        expect_grp(3'h0);
        reg_wr(8'h0c, 32'h7);
        reg_wr(8'h14, 32'ha5);
        foreach (ROWS[i]) begin
            send(ROWS[i].lvl, ROWS[i].pls);
            expect_grp(ROWS[i].exp);
        end
        reg_wr(8'h0c, 32'h2);
        send(8'h00, 8'h02);
        expect_grp(3'h1);
        check({24'h0, group_enabled}, 32'h7);
        send(8'h00, 8'h10);
        expect_grp(3'h1);
        reg_wr(8'h04, 32'h1);
        send(8'h01, 8'h00);
        expect_grp(3'h1);
        reg_wr(8'h08, 32'h3);
        expect_grp(3'h2);
        reg_rd(8'h08, 32'h3);
        reg_wr(8'h10, 32'h2);
        expect_grp(3'h2);
        reg_wr(8'h04, 32'h0);
        expect_grp(3'h0);
        send(8'h00, 8'h00);
        reg_wr(8'h04, 32'h1);
        reg_wr(8'h10, 32'h3);
        expect_grp(3'h2);
        reg_rd(8'h04, 32'h1);
        reg_wr(8'h04, 32'h0);
        expect_grp(3'h2);
        reg_rd(8'h00, 32'h2);
        check({24'h0, active_onehot}, 32'h4);
        reg_wr(8'h10, 32'h2);
        expect_grp(3'h2);
        // status flags gathered so far: refused, not configured, lower priority
        reg_rd(8'h18, 32'h700);
        reg_rd(8'h18, 32'h0);
        reg_wr(8'h0c, 32'h0);
        expect_grp(3'h0);
        // mid-run reset while forced onto group five must restore force, active group, in-use range and forced choice
        reg_wr(8'h0c, 32'h7);
        reg_wr(8'h04, 32'h1);
        reg_wr(8'h08, 32'h5);
        expect_grp(3'h4);
        check({31'h0, force_enable}, 32'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check({15'h0, force_enable, active_onehot, group_enabled}, 32'h0101);
        check({29'h0, active_group}, 32'h0);
        reg_rd(8'h08, 32'h0);
        reg_rd(8'h0c, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
